// ===== hw/reset_seq_consts.svh
// Timing constants for the system reset sequencer
`ifndef RESET_SEQ_CONSTS_SVH
`define RESET_SEQ_CONSTS_SVH
`define RST_HOLD_CYCLES   8'h80
`define COPRO_HIGH_CYCLES 8'h80
`define COPRO_LOW_CYCLES  8'h80
`endif

// ===== hw/reset_seq_pkg.sv
// Types shared by the system reset sequencer
package reset_seq_pkg;
    typedef enum logic [1:0] {
        COP_IDLE,
        COP_HIGH,
        COP_LOW,
        COP_DONE
    } copro_state_t;

    typedef struct packed {
        logic cpu_reset;
        logic system_reset;
        logic copro_reset;
    } reset_outs_t;
endpackage

// ===== hw/system_reset_sequencer.sv
// System reset sequencer: CPU, system and coprocessor reset plus hold-ack gating
`timescale 1ns/1ps
`include "reset_seq_consts.svh"

module system_reset_sequencer (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic power_good_in_n,
    input  wire logic warm_reset_req_n,
    input  wire logic shutdown_cycle,
    input  wire logic sys_port_reset_wr,
    input  wire logic io_cmd_active,
    input  wire logic copro_port_wr,
    input  wire logic cpu_hold_ack_in,
    input  wire logic dma_cycle_active,
    output logic      cpu_reset_out,
    output logic      system_reset_out,
    output logic      copro_reset_out,
    output logic      copro_port_ready,
    output logic      dma_hold_ack_out
);
    // Pin synchronisers: first stage read only by second
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
        end else begin
            sync1 <= {power_good_in_n, warm_reset_req_n, cpu_hold_ack_in ? 1'h0 : 1'h1};
            sync2 <= sync1;
        end
    end
    logic pwr_active;
    logic warm_active;
    logic hold_ack_seen;
    assign pwr_active    = !sync2[2];
    assign warm_active   = !sync2[1];
    assign hold_ack_seen = !sync2[0];

    // Power-on stretch counter
    logic [7:0] pwr_cnt;
    logic       pwr_hold;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_cnt <= `RST_HOLD_CYCLES;
        end else if (pwr_active) begin
            pwr_cnt <= `RST_HOLD_CYCLES;
        end else if (pwr_cnt != 8'h00) begin
            pwr_cnt <= pwr_cnt - 8'h01;
        end
    end
    assign pwr_hold = pwr_active || (pwr_cnt != 8'h00);

    // Port 92H write armed until the command strobe and the DMA cycle have both dropped
    logic port_armed;
    logic port_req;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            port_armed <= 1'h0;
        end else if (sys_port_reset_wr) begin
            port_armed <= 1'h1;
        end else if (port_armed && !io_cmd_active && !dma_cycle_active) begin
            port_armed <= 1'h0;
        end
    end
    assign port_req = port_armed && !io_cmd_active;

    // Warm and port resets defer behind a running DMA cycle, but a reset that
    // collides with a fresh hold ack wins since the DMA has not started yet
    logic soft_req;
    assign soft_req = (warm_active || port_req) && !dma_cycle_active;

    logic next_cpu_reset;
    assign next_cpu_reset = pwr_hold || soft_req || shutdown_cycle;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cpu_reset_out    <= 1'h1;
            system_reset_out <= 1'h1;
        end else begin
            cpu_reset_out    <= next_cpu_reset;
            system_reset_out <= pwr_hold;
        end
    end

    // Hold ack blocked from reset request until reset has completed
    logic hold_block;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hold_block       <= 1'h1;
            dma_hold_ack_out <= 1'h0;
        end else begin
            hold_block       <= next_cpu_reset || (hold_block && cpu_reset_out);
            dma_hold_ack_out <= hold_ack_seen && !next_cpu_reset && !hold_block
                                && !cpu_reset_out;
        end
    end

    // Coprocessor reset pulse sequence
    // Writes during a running sequence are ignored, not queued
    reset_seq_pkg::copro_state_t cop_state;
    logic [7:0]                  cop_cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cop_state <= reset_seq_pkg::COP_IDLE;
            cop_cnt   <= 8'h00;
        end else begin
            unique case (cop_state)
                reset_seq_pkg::COP_IDLE: begin
                    if (copro_port_wr) begin
                        cop_state <= reset_seq_pkg::COP_HIGH;
                        cop_cnt   <= `COPRO_HIGH_CYCLES - 8'h01;
                    end
                end
                reset_seq_pkg::COP_HIGH: begin
                    if (cop_cnt == 8'h00) begin
                        cop_state <= reset_seq_pkg::COP_LOW;
                        cop_cnt   <= `COPRO_LOW_CYCLES - 8'h01;
                    end else begin
                        cop_cnt <= cop_cnt - 8'h01;
                    end
                end
                reset_seq_pkg::COP_LOW: begin
                    if (cop_cnt == 8'h00) begin
                        cop_state <= reset_seq_pkg::COP_DONE;
                    end else begin
                        cop_cnt <= cop_cnt - 8'h01;
                    end
                end
                reset_seq_pkg::COP_DONE: begin
                    cop_state <= reset_seq_pkg::COP_IDLE;
                end
            endcase
        end
    end

    // Outputs registered: high phase is the state one cycle early
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            copro_reset_out  <= 1'h1;
            copro_port_ready <= 1'h0;
        end else begin
            copro_reset_out  <= next_cpu_reset
                || (cop_state == reset_seq_pkg::COP_IDLE && copro_port_wr)
                || (cop_state == reset_seq_pkg::COP_HIGH && cop_cnt != 8'h00);
            copro_port_ready <= (cop_state == reset_seq_pkg::COP_LOW && cop_cnt == 8'h00);
        end
    end

    a_sysrst_follows_pwr: assert property (
        @(posedge clock) disable iff (!nrst) pwr_active |=> (cpu_reset_out && system_reset_out))
        else $error("power good did not assert both resets");
    a_warm_no_sysrst: assert property (
        @(posedge clock) disable iff (!nrst) (warm_active && !pwr_hold) |=> !system_reset_out)
        else $error("warm reset touched system reset");
    a_shutdown_resets: assert property (
        @(posedge clock) disable iff (!nrst) shutdown_cycle |=> cpu_reset_out)
        else $error("shutdown did not reset cpu");
    a_port_after_cmd: assert property (
        @(posedge clock) disable iff (!nrst)
        (port_armed && io_cmd_active && !pwr_hold && !warm_active && !shutdown_cycle)
        |=> !cpu_reset_out)
        else $error("port reset before command ended");
    a_pwr_stretch: assert property (
        @(posedge clock) disable iff (!nrst) $fell(pwr_active) |-> pwr_cnt == `RST_HOLD_CYCLES)
        else $error("stretch counter not loaded");
    a_stretch_holds: assert property (
        @(posedge clock) disable iff (!nrst) (pwr_cnt != 8'h00) |=> system_reset_out)
        else $error("system reset released early");
    a_copro_tracks_cpu: assert property (
        @(posedge clock) disable iff (!nrst) cpu_reset_out |-> copro_reset_out)
        else $error("coprocessor reset missing");
    a_copro_low_phase: assert property (
        @(posedge clock) disable iff (!nrst)
        (cop_state == reset_seq_pkg::COP_LOW && !cpu_reset_out) |-> !copro_reset_out)
        else $error("coprocessor low phase broken");
    a_hold_blocked: assert property (
        @(posedge clock) disable iff (!nrst) cpu_reset_out |-> !dma_hold_ack_out)
        else $error("hold ack forwarded during reset");
    a_dma_defers: assert property (
        @(posedge clock) disable iff (!nrst)
        (dma_cycle_active && !pwr_hold && !shutdown_cycle) |=> !cpu_reset_out)
        else $error("reset during dma cycle");
    a_hold_pass: assert property (
        @(posedge clock) disable iff (!nrst)
        (hold_ack_seen && !next_cpu_reset && !hold_block && !cpu_reset_out) |=> dma_hold_ack_out)
        else $error("hold ack not passed");

    // Output timing checks; the sequence length is two fixed 128-cycle phases
    // plus the registered ready, so it must track the constants above
    a_cpu_rst_sync: assert property (
        @(posedge clock) disable iff (!nrst) next_cpu_reset |=> cpu_reset_out)
        else $error("cpu reset not registered on the clock");
    a_cpu_rst_release: assert property (
        @(posedge clock) disable iff (!nrst) !next_cpu_reset |=> !cpu_reset_out)
        else $error("cpu reset held without a cause");
    a_sysrst_pwr_only: assert property (
        @(posedge clock) disable iff (!nrst) !pwr_hold |=> !system_reset_out)
        else $error("system reset without power good cause");
    a_port_fires: assert property (
        @(posedge clock) disable iff (!nrst)
        (port_armed && !io_cmd_active && !dma_cycle_active) |=> cpu_reset_out)
        else $error("port reset not issued after command");
    a_copro_seq_len: assert property (
        @(posedge clock) disable iff (!nrst)
        (cop_state == reset_seq_pkg::COP_IDLE && copro_port_wr) |-> ##257 copro_port_ready)
        else $error("coprocessor sequence length wrong");
    a_ready_one_cycle: assert property (
        @(posedge clock) disable iff (!nrst) copro_port_ready |=> !copro_port_ready)
        else $error("ready pulse too long");
endmodule

// ===== tb/cpu_side_model.sv
// Processor side model: returns hold acknowledge, dropping it in reset
`timescale 1ns/1ps
module cpu_side_model #(
    parameter bit SLOW = 1'h0
) (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic hold_req,
    input  wire logic cpu_reset,
    output logic      hold_ack
);
    logic late;
    // Real processor lets go of hold ack once reset hits it
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            late <= 1'h0;
        end else begin
            late <= hold_req & ~cpu_reset;
        end
    end
    assign hold_ack = SLOW ? late : (hold_req & ~cpu_reset);
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the system reset sequencer
`timescale 1ns/1ps
module testbench;
    logic       clock, nrst, power_good_in_n, warm_reset_req_n, shutdown_cycle;
    logic       sys_port_reset_wr, io_cmd_active, copro_port_wr, hold_req;
    logic       dma_cycle_active, cpu_hold_ack_in, hit;
    logic       cpu_reset_out, system_reset_out, copro_reset_out;
    logic       copro_port_ready, dma_hold_ack_out;
    int         err_total = 0;
    int         n_tests = 0;
    reset_seq_pkg::reset_outs_t outs;
    logic [2:0] cp;
    assign outs = {cpu_reset_out, system_reset_out, copro_reset_out};
    assign cp = {copro_reset_out, copro_port_ready, 1'h0};

    system_reset_sequencer i_dut (.clock(clock), .nrst(nrst),
        .power_good_in_n(power_good_in_n), .warm_reset_req_n(warm_reset_req_n),
        .shutdown_cycle(shutdown_cycle), .sys_port_reset_wr(sys_port_reset_wr),
        .io_cmd_active(io_cmd_active), .copro_port_wr(copro_port_wr),
        .cpu_hold_ack_in(cpu_hold_ack_in), .dma_cycle_active(dma_cycle_active),
        .cpu_reset_out(cpu_reset_out), .system_reset_out(system_reset_out),
        .copro_reset_out(copro_reset_out), .copro_port_ready(copro_port_ready),
        .dma_hold_ack_out(dma_hold_ack_out));
    cpu_side_model i_cpu (.clock(clock), .nrst(nrst), .hold_req(hold_req),
        .cpu_reset(cpu_reset_out), .hold_ack(cpu_hold_ack_in));

    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Reset may be short, so look every cycle
    task catch_rst(input int n);
        hit = 1'h0;
        repeat (n) begin
            #1;
            if (cpu_reset_out === 1'h1) hit = 1'h1;
            @(posedge clock);
        end
    endtask
    task power_good;
        @(posedge clock) power_good_in_n <= 1'h0;
        tick(5);
        chk("pg resets", outs, 3'h7);
        @(posedge clock) power_good_in_n <= 1'h1;
        repeat (128) begin
            tick(1);
            chk("pg stretch", outs, 3'h7);
        end
        tick(8);
        chk("pg end", outs, 3'h0);
    endtask
    task warm_with_hold;
        @(posedge clock) begin
            warm_reset_req_n <= 1'h0;
            hold_req <= 1'h1;
        end
        tick(5);
        chk("warm resets", outs, 3'h5);
        chk("hold ack held", {2'h0, dma_hold_ack_out}, 3'h0);
        @(posedge clock) warm_reset_req_n <= 1'h1;
        tick(12);
        chk("after warm", outs, 3'h0);
        chk("hold ack sent", {2'h0, dma_hold_ack_out}, 3'h1);
        @(posedge clock) hold_req <= 1'h0;
        tick(6);
        chk("hold ack off", {2'h0, dma_hold_ack_out}, 3'h0);
    endtask
    task shutdown;
        @(posedge clock) shutdown_cycle <= 1'h1;
        @(posedge clock) shutdown_cycle <= 1'h0;
        catch_rst(4);
        chk("shutdown", {2'h0, hit}, 3'h1);
        tick(8);
    endtask
    task port_reset;
        @(posedge clock) begin
            io_cmd_active <= 1'h1;
            dma_cycle_active <= 1'h1;
            sys_port_reset_wr <= 1'h1;
        end
        @(posedge clock) sys_port_reset_wr <= 1'h0;
        catch_rst(8);
        chk("port during cmd", {2'h0, hit}, 3'h0);
        @(posedge clock) io_cmd_active <= 1'h0;
        catch_rst(8);
        chk("port during dma", {2'h0, hit}, 3'h0);
        @(posedge clock) dma_cycle_active <= 1'h0;
        catch_rst(4);
        chk("port fires", {2'h0, hit}, 3'h1);
        tick(8);
    endtask
    task copro_seq;
        @(posedge clock) copro_port_wr <= 1'h1;
        @(posedge clock) copro_port_wr <= 1'h0;
        tick(1);
        chk("copro high", outs, 3'h1);
        // Second write mid-sequence must not restart it
        @(posedge clock) copro_port_wr <= 1'h1;
        @(posedge clock) copro_port_wr <= 1'h0;
        tick(124);
        chk("copro high end", cp, 3'h4);
        tick(1);
        chk("copro low", cp, 3'h0);
        tick(127);
        chk("copro low end", cp, 3'h0);
        tick(1);
        chk("copro ready", cp, 3'h2);
        tick(1);
        chk("ready pulse", cp, 3'h0);
    endtask
    task conclude;
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    initial begin
        #20000;
        err_total++;
        conclude;
    end
    initial begin
        {nrst, shutdown_cycle, sys_port_reset_wr, io_cmd_active} = 4'h0;
        {copro_port_wr, hold_req, dma_cycle_active} = 3'h0;
        {power_good_in_n, warm_reset_req_n} = 2'h3;
        repeat (4) @(posedge clock);
        nrst <= 1'h1;
        power_good;
        warm_with_hold;
        shutdown;
        port_reset;
        copro_seq;
        conclude;
    end
endmodule
